// [rtl/pim_pkg.sv]
// Constants and types of the platform interrupt merger
// Contract
// - A gateway holds a captured request until its completion write or a reset.
// - Every implemented source has its own gateway feeding its pending bit.
// - The enable register enables each source singly; only enabled sources raise the output.
// - A gateway that asserts sets its pending bit, held until completion or reset.
// - The merged output rises while a source is enabled and pending, until claimed or reset.
// - Among several enabled pending sources the lowest number is presented first.
// - Reading the claim/complete register returns the ID of the source chosen for service.
// - Software writes the source ID to claim/complete; its gateway and pending bit clear.
// - The source count is a build parameter from 1 to 31, default 8.
// - A build parameter of 0 or 1 removes or keeps the controller, default 0.
// - Source lines are active high; a peripheral drives high to request service.
// - Pending register bit 0 is reserved, bit n reports source n, resets to zero.
// - Enable register bit 0 is reserved, bit n enables source n, resets to zero.
// - Pending sits at 0x1000, enable at 0x2000, claim/complete at 0x200004.
package pim_pkg;

    localparam int          PIM_ADDR_W        = 22;
    localparam int          PIM_DATA_W        = 32;
    localparam int          PIM_ID_W          = 5;
    localparam int          PIM_MAX_SOURCES   = 31;
    localparam int          PIM_DEF_SOURCES   = 8;
    localparam bit          PIM_DEF_PRESENT   = 1'b0;

    localparam logic [21:0] PIM_OFF_PENDING   = 22'h001000;
    localparam logic [21:0] PIM_OFF_ENABLE    = 22'h002000;
    localparam logic [21:0] PIM_OFF_CLAIM     = 22'h200004;

    localparam logic [31:0] PIM_RESET_WORD    = 32'h00000000;
    localparam logic [4:0]  PIM_NO_SOURCE_ID  = 5'h00;

    // Whole state of the controller
    typedef struct packed {
        logic [31:0] gateway;
        logic [31:0] pending;
        logic [31:0] enable;
        logic [31:0] claimed;
        logic [31:0] rdata;
        logic        irq;
    } pim_state_t;

    // Register access request
    typedef struct packed {
        logic [21:0] addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } pim_req_t;

endpackage

// [rtl/pim_merger.sv]
// Platform interrupt merger: gateways, pending, enable and claim/complete
`timescale 1ns/1ps
`default_nettype none

module pim_merger
    import pim_pkg::*;
#(
    parameter int SOURCE_COUNT       = PIM_DEF_SOURCES,
    parameter bit CONTROLLER_PRESENT = PIM_DEF_PRESENT
) (
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic [31:0] INTERRUPT_SOURCE_LINES,
    input  wire logic [21:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    output var  logic [31:0] REG_RDATA,
    output var  logic        MERGED_INTERRUPT_OUT
);

    //--------------------------------------------------------------
    // Implemented source mask
    //--------------------------------------------------------------
    logic [31:0] impl_mask;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_mask
            assign impl_mask[gi] = CONTROLLER_PRESENT && (gi >= 1) && (gi <= SOURCE_COUNT);
        end
    endgenerate

    //--------------------------------------------------------------
    // Lowest-numbered selection
    //--------------------------------------------------------------
    function automatic logic [4:0] pim_lowest(input logic [31:0] vec);
        logic [4:0] id;
        id = PIM_NO_SOURCE_ID;
        for (int i = PIM_MAX_SOURCES; i >= 1; i--) begin
            if (vec[i]) begin
                id = 5'(i);
            end
        end
        return id;
    endfunction

    //--------------------------------------------------------------
    // State update
    //--------------------------------------------------------------
    pim_state_t  state;
    pim_state_t  next_state;
    pim_req_t    req;
    logic [31:0] src_req;
    logic [31:0] serviceable;
    logic [31:0] complete_clr;
    logic [31:0] claim_set;
    logic [4:0]  sel_id;
    logic [4:0]  done_id;

    assign req = '{addr: REG_ADDR, wr: REG_WR, rd: REG_RD, wdata: REG_WDATA};

    always_comb begin
        next_state   = state;
        src_req      = INTERRUPT_SOURCE_LINES & impl_mask;
        serviceable  = state.enable & state.pending & ~state.claimed & impl_mask;
        sel_id       = pim_lowest(serviceable);
        done_id      = req.wdata[PIM_ID_W-1:0];
        complete_clr = '0;
        claim_set    = '0;

        // completion write clears gateway and pending
        if (req.wr && req.addr == PIM_OFF_CLAIM && done_id != PIM_NO_SOURCE_ID) begin
            complete_clr[done_id] = 1'b1;
        end
        complete_clr = complete_clr & impl_mask;

        // claim read marks the chosen source in service
        if (req.rd && req.addr == PIM_OFF_CLAIM && sel_id != PIM_NO_SOURCE_ID) begin
            claim_set[sel_id] = 1'b1;
        end

        // gateway holds until completion; a new request wins over the clear
        next_state.gateway = (state.gateway & ~complete_clr) | src_req;
        // gateway sets pending, held until completion
        next_state.pending = ((state.pending | state.gateway) & ~complete_clr) & impl_mask;
        next_state.claimed = ((state.claimed & ~complete_clr) | claim_set) & impl_mask;

        if (req.wr && req.addr == PIM_OFF_ENABLE) begin
            next_state.enable = req.wdata & impl_mask;
        end

        if (req.rd) begin
            case (req.addr)
                PIM_OFF_PENDING: next_state.rdata = state.pending & impl_mask;
                PIM_OFF_ENABLE:  next_state.rdata = state.enable & impl_mask;
                PIM_OFF_CLAIM:   next_state.rdata = {27'h0000000, sel_id};
                default:         next_state.rdata = PIM_RESET_WORD;
            endcase
        end

        // merged output while enabled and pending, until claimed
        next_state.irq = |(((state.enable & state.pending & ~state.claimed) & ~claim_set)
                           & impl_mask);
    end

    // single clock, synchronous reset clears all
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state <= '{gateway: PIM_RESET_WORD, pending: PIM_RESET_WORD,
                       enable: PIM_RESET_WORD, claimed: PIM_RESET_WORD,
                       rdata: PIM_RESET_WORD, irq: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign REG_RDATA            = state.rdata;
    assign MERGED_INTERRUPT_OUT = state.irq;

endmodule // pim_merger

`default_nettype wire

// [verif/pim_merger_asserts.sv]
// Port checker of the interrupt merger
`timescale 1ns/1ps
`default_nettype none
module pim_merger_asserts import pim_pkg::*; (
    input wire logic SYS_CLK, SYS_RST, REG_WR, REG_RD, MERGED_INTERRUPT_OUT,
    input wire logic [31:0] INTERRUPT_SOURCE_LINES, REG_WDATA, REG_RDATA,
    input wire logic [21:0] REG_ADDR);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    wire irq = MERGED_INTERRUPT_OUT, any = |INTERRUPT_SOURCE_LINES;
    wire cl = REG_ADDR == PIM_OFF_CLAIM;
    wire [31:0] q = REG_RDATA;
    chk_reset_clear: assert property ($fell(SYS_RST) |-> !irq && q == 0)
        else $error("not clear");
    chk_unmapped_zero: assert property (REG_RD && !REG_ADDR[21] && |REG_ADDR[11:0]
        |=> q == 0) else $error("unmapped data");
    chk_bit0_zero: assert property (REG_RD && !cl |=> !q[0]) else $error("bit 0");
    chk_data_holds: assert property (!REG_RD |=> $stable(q)) else $error("moved");
    chk_irq_cause: assert property ($rose(irq) |->
        $past(REG_WR, 2) || $past(any, 3) || $past(any, 4)) else $error("no cause");
    chk_off_quiet: assert property (REG_WR && REG_ADDR == PIM_OFF_ENABLE &&
        REG_WDATA == 0 |-> ##2 !irq) else $error("irq while off");
    chk_claim_id: assert property (REG_RD && cl && irq |=> q inside {[1:31]})
        else $error("no id");
    chk_irq_stands: assert property (irq && !REG_RD && !REG_WR && !$past(REG_WR) |=> irq)
        else $error("irq dropped");
    cover property (REG_RD && cl && irq);
    cover property ($fell(irq));
    cover property (REG_WR && cl);
endmodule // pim_merger_asserts
bind pim_merger pim_merger_asserts u_chk (.*);
`default_nettype wire

// [verif/pim_peers.sv]
// Peripherals that raise the source lines
`timescale 1ns/1ps
`default_nettype none
module pim_peers (
    input  wire logic        SYS_CLK,
    input  wire logic [31:0] rq,
    output var  logic [31:0] lines = 32'h0);
    always @(posedge SYS_CLK) lines <= rq;
endmodule // pim_peers
`default_nettype wire

// [verif/pim_merger_bench.sv]
// Self-checking bench of the interrupt merger
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t %h %h", $time, a, e); end end
module pim_merger_bench import pim_pkg::*;;
    localparam logic rd = 1'h0, wr = 1'h1;
    localparam logic [21:0] pn = PIM_OFF_PENDING, en = PIM_OFF_ENABLE, cl = PIM_OFF_CLAIM;
    logic SYS_CLK = 1'h0, SYS_RST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, MERGED_INTERRUPT_OUT;
    logic [21:0] REG_ADDR = 22'h0;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, INTERRUPT_SOURCE_LINES, rq = 32'h0;
    int n_mismatch = 0, compares = 0, cyc = 0;
    pim_peers peers (.SYS_CLK, .rq, .lines(INTERRUPT_SOURCE_LINES));
    pim_merger #(.SOURCE_COUNT(8), .CONTROLLER_PRESENT(1'h1)) dut (.SYS_CLK, .SYS_RST,
        .INTERRUPT_SOURCE_LINES, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
        .MERGED_INTERRUPT_OUT);
    task automatic acc(logic w, logic [21:0] a, logic [31:0] d, logic [31:0] m = 32'h0);
        @(posedge SYS_CLK) #1;
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA, rq} = {w, !w, a, d, m};
        @(posedge SYS_CLK) #1;
        {REG_WR, REG_RD, rq} = 34'h0;
        if (!w) `CHK(REG_RDATA, d)
    endtask
    task automatic close_out(int t);
        n_mismatch += t;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #25 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (++cyc == 500) close_out(1);
    initial begin
        repeat (16) @(posedge SYS_CLK);
        #1 SYS_RST = 1'h0;
        acc(rd, pn, 32'h0);
        acc(wr, en, 32'hFFFFFFFF);
        acc(rd, en, 32'h1FE, 32'h42);
        acc(rd, 22'h1004, 32'h0);
        acc(wr, pn, 32'h0);
        `CHK(MERGED_INTERRUPT_OUT, 1'h1)
        acc(rd, pn, 32'h42);
        acc(rd, cl, 32'h1);
        acc(rd, cl, 32'h6);
        `CHK(MERGED_INTERRUPT_OUT, 1'h0)
        acc(wr, cl, 32'h1);
        acc(wr, cl, 32'h6);
        acc(wr, en, 32'h4, 32'h28);
        acc(rd, en, 32'h4);
        acc(rd, pn, 32'h28);
        acc(rd, cl, 32'h0);
        `CHK(MERGED_INTERRUPT_OUT, 1'h0)
        acc(wr, en, 32'h20);
        @(posedge SYS_CLK) #1;
        `CHK(MERGED_INTERRUPT_OUT, 1'h1)
        acc(wr, en, 32'h0);
        acc(rd, cl, 32'h0);
        close_out(0);
    end
endmodule // pim_merger_bench
`default_nettype wire
